// File: verilog/interpolating_quadrature_modulator.sv
// Interpolation chain and digital quadrature modulator of a dual DAC transmit path.
// Assumes host samples on mclk, taken on sample_take; output feeds the DAC cores each mclk.
//
// Chosen here: the register addresses and the address-and-strobe port.
module interpolating_quadrature_modulator
    import modulator_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire iq_sample_type in_sample,
    output logic sample_take,
    output iq_sample_type dac_out,
    output logic dac_i_power_down,
    output logic dac_q_power_down,
    output logic filters_power_down,
    output logic full_power_down
);

    state_type state_reg;
    state_type state_next;
    logic frozen;
    logic mod_strobe;

    function automatic logic strobe(input logic [2:0] cnt, input logic [1:0] lg);
        logic [2:0] mask;
        mask = (3'b001 << lg) - 3'b001;
        return (cnt & mask) == 3'b000;
    endfunction

    function automatic logic signed [15:0] sat16(input logic signed [20:0] v);
        logic signed [15:0] r;
        if (v > 21'(SAMPLE_MAX)) begin
            r = SAMPLE_MAX;
        end else if (v < 21'(SAMPLE_MIN)) begin
            r = SAMPLE_MIN;
        end else begin
            r = v[15:0];
        end
        return r;
    endfunction

    // Odd phase of the half-band: -x0 + 9x1 + 9x2 - x3, scaled back by 16
    function automatic logic signed [15:0] halfband_mid(input logic signed [15:0] x0, input logic signed [15:0] x1,
                                                         input logic signed [15:0] x2, input logic signed [15:0] x3);
        logic signed [20:0] acc;
        acc = HB_TAP_INNER * x1 + HB_TAP_INNER * x2 - x0 - x3;
        return sat16(acc >>> HB_SHIFT);
    endfunction

    function automatic logic signed [20:0] mix(input logic signed [15:0] a, input coef_type c);
        logic signed [20:0] r;
        case (c)
            COEF_POS: r = 21'(a);
            COEF_NEG: r = -21'(a);
            default: r = '0;
        endcase
        return r;
    endfunction

    // Quarter-rate cosine table; sine reads it one phase behind
    function automatic coef_type quarter_cos(input logic [1:0] ph);
        coef_type c;
        case (ph)
            2'b00: c = COEF_POS;
            2'b10: c = COEF_NEG;
            default: c = COEF_ZERO;
        endcase
        return c;
    endfunction

    // Both DACs down means everything down; the filters then hold too
    assign frozen = state_reg.pd_filter | (state_reg.pd_i & state_reg.pd_q);
    assign mod_strobe = strobe(state_reg.cnt, (state_reg.interp == INTERP_8X) ? 2'b01 : 2'b00);

    always_comb begin
        logic [1:0] lgf;
        logic [1:0] in_lg;
        iq_sample_type stage_in;
        iq_sample_type mid;
        logic signed [15:0] a;
        logic signed [15:0] b;
        coef_type c_cos;
        coef_type c_sin;
        logic signed [20:0] b_sin;
        lgf = state_reg.interp;
        in_lg = 2'b00;
        stage_in = '0;
        mid = '0;
        a = state_reg.stage_out[1].i;
        b = state_reg.stage_out[1].q;
        c_cos = COEF_ZERO;
        c_sin = COEF_ZERO;
        b_sin = '0;
        state_next = state_reg;
        state_next.cnt = state_reg.cnt + 3'b001;
        state_next.rdata = READ_IDLE;

        if (!frozen) begin
            // Stage k runs when k is below the log2 factor; idle stages pass through
            for (int k = 0; k < STAGES; k++) begin
                if (k == 0) begin
                    stage_in = in_sample;
                end else if (k == 1) begin
                    stage_in = state_reg.stage_out[0];
                end else begin
                    stage_in = state_reg.mod_out;
                end
                if (k < int'(lgf)) begin
                    in_lg = 2'(int'(lgf) - k);
                    if (strobe(state_reg.cnt, in_lg)) begin
                        state_next.hist[k] = {state_reg.hist[k][TAPS-2:0], stage_in};
                        state_next.stage_out[k] = state_reg.hist[k][1];
                    end else if (strobe(state_reg.cnt, in_lg - 2'b01)) begin
                        mid.i = halfband_mid(state_reg.hist[k][0].i, state_reg.hist[k][1].i,
                                             state_reg.hist[k][2].i, state_reg.hist[k][3].i);
                        mid.q = halfband_mid(state_reg.hist[k][0].q, state_reg.hist[k][1].q,
                                             state_reg.hist[k][2].q, state_reg.hist[k][3].q);
                        // Highpass twin flips the odd-phase taps only
                        if (k == STAGES - 1 && state_reg.highpass) begin
                            mid.i = sat16(-21'(mid.i));
                            mid.q = sat16(-21'(mid.q));
                        end
                        state_next.stage_out[k] = mid;
                    end
                end else begin
                    state_next.stage_out[k] = stage_in;
                end
            end

            if (mod_strobe) begin
                state_next.lo_phase = state_reg.lo_phase + 2'b01;
                c_cos = quarter_cos(state_reg.lo_phase);
                c_sin = quarter_cos(state_reg.lo_phase - 2'b01);
                b_sin = state_reg.lo_neg ? mix(b, c_sin) : -mix(b, c_sin);
                case (state_reg.lo_sel)
                    LO_HALF: begin
                        // Complex mode bit is ignored here: real only
                        c_cos = state_reg.lo_phase[0] ? COEF_POS : COEF_NEG;
                        state_next.mod_out.i = sat16(mix(a, c_cos));
                        state_next.mod_out.q = sat16(mix(a, c_cos));
                    end
                    LO_QUARTER: begin
                        if (state_reg.cplx) begin
                            state_next.mod_out.i = sat16(mix(a, c_cos) + b_sin);
                            state_next.mod_out.q = sat16(mix(a, c_sin) + mix(b, c_cos));
                        end else begin
                            state_next.mod_out.i = sat16(mix(a, c_cos));
                            state_next.mod_out.q = sat16(mix(a, c_cos));
                        end
                    end
                    default: begin
                        state_next.mod_out = state_reg.stage_out[1];
                    end
                endcase
            end
            state_next.dac_out = state_reg.stage_out[STAGES-1];
        end

        if (reg_read) begin
            case (reg_addr)
                CTRL0_ADDR: begin
                    state_next.rdata[PD_FILTER_BIT] = state_reg.pd_filter;
                    state_next.rdata[PD_Q_BIT] = state_reg.pd_q;
                    state_next.rdata[PD_I_BIT] = state_reg.pd_i;
                end
                MODE_ADDR: begin
                    state_next.rdata[INTERP_HI:INTERP_LO] = state_reg.interp;
                    state_next.rdata[HIGHPASS_BIT] = state_reg.highpass;
                    state_next.rdata[LO_SEL_HI:LO_SEL_LO] = state_reg.lo_sel;
                    state_next.rdata[COMPLEX_BIT] = state_reg.cplx;
                    state_next.rdata[LO_SIGN_BIT] = state_reg.lo_neg;
                end
                STATUS_ADDR: begin
                    state_next.rdata[STATUS_FULL_PD_BIT] = state_reg.pd_i & state_reg.pd_q;
                    state_next.rdata[STATUS_PHASE_HI:STATUS_PHASE_LO] = state_reg.lo_phase;
                end
                default: begin
                    state_next.rdata = READ_IDLE;
                end
            endcase
        end

        if (reg_write && reg_addr == CTRL0_ADDR) begin
            state_next.pd_filter = reg_wdata[PD_FILTER_BIT];
            state_next.pd_q = reg_wdata[PD_Q_BIT];
            state_next.pd_i = reg_wdata[PD_I_BIT];
        end
        if (reg_write && reg_addr == MODE_ADDR) begin
            state_next.interp = interp_type'(reg_wdata[INTERP_HI:INTERP_LO]);
            state_next.highpass = reg_wdata[HIGHPASS_BIT];
            // Unused code 3 of the LO select falls back to off
            state_next.lo_sel = lo_sel_type'(reg_wdata[LO_SEL_HI:LO_SEL_LO]);
            state_next.cplx = reg_wdata[COMPLEX_BIT];
            state_next.lo_neg = reg_wdata[LO_SIGN_BIT];
        end
        // Soft reset wins over everything, LO phase included
        if (reg_write && reg_addr == CTRL0_ADDR && reg_wdata[SOFT_RESET_BIT]) begin
            state_next = STATE_RESET;
        end
    end

    // Defaults and LO phase zero from the reset edge on
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata = state_reg.rdata;
    assign dac_out = state_reg.dac_out;
    assign sample_take = !frozen && strobe(state_reg.cnt, state_reg.interp);
    assign dac_i_power_down = state_reg.pd_i;
    assign dac_q_power_down = state_reg.pd_q;
    assign filters_power_down = frozen;
    assign full_power_down = state_reg.pd_i & state_reg.pd_q;

    // A mode change or soft reset inside the window may legally speed the takes up
    take_rate_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (sample_take && state_reg.interp == INTERP_8X)
        |=> (!sample_take || state_reg.interp != INTERP_8X) [*7])
        else $error("8x input taken more than once per eight cycles");

    interp_field_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (reg_write && reg_addr == MODE_ADDR)
        |=> state_reg.interp == $past(reg_wdata[INTERP_HI:INTERP_LO]))
        else $error("interpolation field not loaded from register 1");

    mod_rate_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (mod_strobe && state_reg.interp == INTERP_8X && !frozen && !reg_write) |=> !mod_strobe)
        else $error("modulator ran at full rate in 8x mode");

    cos_zero_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (mod_strobe && !frozen && !reg_write && state_reg.lo_sel == LO_QUARTER && !state_reg.cplx
         && state_reg.lo_phase[0]) |=> state_reg.mod_out.i == 16'sh0000)
        else $error("quarter-rate cosine not zero on odd phase");

    real_equal_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (mod_strobe && !frozen && !reg_write && state_reg.lo_sel == LO_QUARTER && !state_reg.cplx)
        |=> state_reg.mod_out.i == state_reg.mod_out.q)
        else $error("real modulation outputs differ");

    half_real_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (mod_strobe && !frozen && !reg_write && state_reg.lo_sel == LO_HALF)
        |=> state_reg.mod_out.i == state_reg.mod_out.q)
        else $error("half-rate LO produced complex output");

    hold_output_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_reg.pd_filter && !reg_write) |=> $stable(dac_out))
        else $error("DAC output moved while filters were down");

    full_down_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_reg.pd_i && state_reg.pd_q) |-> (filters_power_down && !sample_take))
        else $error("both DACs down without full power-down");

    soft_reset_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (reg_write && reg_addr == CTRL0_ADDR && reg_wdata[SOFT_RESET_BIT])
        |=> (state_reg.lo_phase == 2'b00 && state_reg.interp == INTERP_1X && !state_reg.pd_i
             && state_reg.lo_sel == LO_OFF))
        else $error("soft reset did not restore defaults");

    cover_8x_take: cover property (@(posedge mclk) disable iff (!reset_n)
        sample_take && state_reg.interp == INTERP_8X && state_reg.highpass);
    cover_complex: cover property (@(posedge mclk) disable iff (!reset_n)
        mod_strobe && state_reg.lo_sel == LO_QUARTER && state_reg.cplx && state_reg.lo_neg);
    cover_half: cover property (@(posedge mclk) disable iff (!reset_n)
        mod_strobe && state_reg.lo_sel == LO_HALF && state_reg.interp == INTERP_4X);
    cover_full_down: cover property (@(posedge mclk) disable iff (!reset_n) full_power_down);

endmodule

// File: verilog/modulator_pkg.sv
// Constants, carriers and state layout for the interpolating quadrature modulator.
// Assumes one clock domain; registers are 8 bits wide on a plain strobe port.
package modulator_pkg;

    // Register addresses
    localparam logic [7:0] CTRL0_ADDR = 8'h00;
    localparam logic [7:0] MODE_ADDR = 8'h01;
    localparam logic [7:0] STATUS_ADDR = 8'h03;

    // Control register 0 bit positions
    localparam int SOFT_RESET_BIT = 5;
    localparam int PD_FILTER_BIT = 4;
    localparam int PD_Q_BIT = 3;
    localparam int PD_I_BIT = 2;

    // Mode register 1 bit positions
    localparam int INTERP_HI = 7;
    localparam int INTERP_LO = 6;
    localparam int HIGHPASS_BIT = 5;
    localparam int LO_SEL_HI = 4;
    localparam int LO_SEL_LO = 3;
    localparam int COMPLEX_BIT = 2;
    localparam int LO_SIGN_BIT = 1;

    // Status register bit positions
    localparam int STATUS_FULL_PD_BIT = 7;
    localparam int STATUS_PHASE_HI = 1;
    localparam int STATUS_PHASE_LO = 0;

    localparam logic [7:0] READ_IDLE = 8'h00;

    // Reset pulse figures
    localparam int CLK_PERIOD_NS = 4;
    localparam int RESET_MIN_NS = 10;
    localparam int RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Half-band filter shape
    localparam int STAGES = 3;
    localparam int TAPS = 4;
    localparam int ACC_W = 21;
    localparam logic signed [20:0] HB_TAP_INNER = 21'sh0_0009;
    localparam int HB_SHIFT = 4;
    localparam logic signed [15:0] SAMPLE_MAX = 16'sh7fff;
    localparam logic signed [15:0] SAMPLE_MIN = -16'sh7fff - 16'sh0001;

    typedef enum logic [1:0] {
        INTERP_1X = 2'b00,
        INTERP_2X = 2'b01,
        INTERP_4X = 2'b10,
        INTERP_8X = 2'b11
    } interp_type;

    typedef enum logic [1:0] {
        LO_OFF = 2'b00,
        LO_HALF = 2'b01,
        LO_QUARTER = 2'b10
    } lo_sel_type;

    typedef enum logic [1:0] {
        COEF_ZERO = 2'b00,
        COEF_POS = 2'b01,
        COEF_NEG = 2'b10
    } coef_type;

    typedef struct packed {
        logic signed [15:0] i;
        logic signed [15:0] q;
    } iq_sample_type;

    typedef struct packed {
        logic [2:0] cnt;
        logic pd_i;
        logic pd_q;
        logic pd_filter;
        interp_type interp;
        logic highpass;
        lo_sel_type lo_sel;
        logic cplx;
        logic lo_neg;
        logic [1:0] lo_phase;
        logic [7:0] rdata;
        iq_sample_type [STAGES-1:0][TAPS-1:0] hist;
        iq_sample_type [STAGES-1:0] stage_out;
        iq_sample_type mod_out;
        iq_sample_type dac_out;
    } state_type;

    // Every field defaults to zero: 1x, modulator off, everything powered
    localparam state_type STATE_RESET = '0;

endpackage

// File: testbench/sample_source.sv
// Host-side source of I/Q sample words for the modulator bench.
// Assumes the block takes a word on each mclk edge where sample_take is high.
module sample_source
    import modulator_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic sample_take,
    input wire iq_sample_type next_sample,
    output iq_sample_type in_sample,
    output int take_count
);
    timeunit 1ns;
    timeprecision 1ps;

    // New word only after a take, never under the edge that samples it
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            in_sample <= '0;
            take_count <= 0;
        end else if (sample_take) begin
            in_sample <= next_sample;
            take_count <= take_count + 1;
        end
    end
endmodule

// File: testbench/tb_interpolating_quadrature_modulator.sv
// Self-checking bench for the interpolating quadrature modulator.
// Assumes a constant host word from sample_source and registers on a one-cycle strobe port.
`define CHECK(what, exp, got) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("unexpected %s: expected %h, seen %h", what, exp, got); \
    end \
end

module tb_interpolating_quadrature_modulator
    import modulator_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic signed [15:0] A = 16'sh1000;
    localparam logic signed [15:0] B = 16'sh0300;
    localparam logic signed [15:0] NA = 16'shf000;
    localparam logic signed [15:0] NB = 16'shfd00;
    localparam logic signed [15:0] Z = 16'sh0000;

    typedef iq_sample_type seq_type [4];

    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    iq_sample_type in_sample;
    iq_sample_type next_sample = '{A, B};
    logic sample_take;
    iq_sample_type dac_out;
    iq_sample_type hold;
    logic dac_i_power_down;
    logic dac_q_power_down;
    logic filters_power_down;
    logic full_power_down;
    int take_count;
    int c0;
    int mismatches = 0;
    int num_checks = 0;
    logic [7:0] rv;
    logic [7:0] p0;
    logic [7:0] ref_status;
    logic [7:0] pd_val [4] = '{8'h04, 8'h08, 8'h10, 8'h0c};
    logic [3:0] pd_exp [4] = '{4'b1000, 4'b0100, 4'b0010, 4'b1111};

    always #2 mclk = ~mclk;

    interpolating_quadrature_modulator i_dut (
        .mclk(mclk),
        .reset_n(reset_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write),
        .reg_read(reg_read),
        .reg_rdata(reg_rdata),
        .in_sample(in_sample),
        .sample_take(sample_take),
        .dac_out(dac_out),
        .dac_i_power_down(dac_i_power_down),
        .dac_q_power_down(dac_q_power_down),
        .filters_power_down(filters_power_down),
        .full_power_down(full_power_down)
    );

    sample_source i_source (
        .mclk(mclk),
        .reset_n(reset_n),
        .sample_take(sample_take),
        .next_sample(next_sample),
        .in_sample(in_sample),
        .take_count(take_count)
    );

    function automatic logic [7:0] mv(interp_type f, logic hp, lo_sel_type lo, logic cx, logic ng);
        return {f, hp, lo, cx, ng, 1'b0};
    endfunction

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask

    // Read data stands one cycle only, so it is taken mid-cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge mclk);
        reg_read <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask

    // Held past the 10 ns minimum; released on an edge, so it counts from the next one
    task automatic do_reset();
        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (RESET_MIN_CYCLES) @(posedge mclk);
        reset_n <= 1'b1;
    endtask

    // Latency is unknown, so lock onto the first word of the pattern
    task automatic run_mode(input logic [7:0] m, input seq_type s);
        int n;
        wr(MODE_ADDR, m);
        repeat (128) @(negedge mclk);
        n = 0;
        while (dac_out !== s[0] && n < 256) begin
            @(negedge mclk);
            n++;
        end
        for (int k = 0; k < 8; k++) begin
            `CHECK("dac_out", s[k % 4], dac_out)
            @(negedge mclk);
        end
    endtask

    initial begin
        fork
            begin
                repeat (30000) @(posedge mclk);
                mismatches++;
                give_verdict();
            end
        join_none
        do_reset();
        rd(STATUS_ADDR, ref_status);
        `CHECK("start phase first", 8'h01, ref_status)
        rd(MODE_ADDR, rv);
        `CHECK("mode reset", 8'h00, rv)
        rd(CTRL0_ADDR, rv);
        `CHECK("ctrl0 reset", 8'h00, rv)
        rd(8'h02, rv);
        `CHECK("unmapped read", 8'h00, rv)
        wr(MODE_ADDR, 8'he5);
        rd(MODE_ADDR, rv);
        `CHECK("mode readback", 8'he4, rv)
        wr(CTRL0_ADDR, 8'h24);
        rd(MODE_ADDR, rv);
        `CHECK("mode soft reset", 8'h00, rv)
        `CHECK("i power-down soft reset", 1'b0, dac_i_power_down)
        for (int f = 0; f < 4; f++) begin
            run_mode(mv(interp_type'(f), 1'b0, LO_OFF, 1'b0, 1'b0), '{'{A, B}, '{A, B}, '{A, B}, '{A, B}});
            c0 = take_count;
            repeat (64) @(negedge mclk);
            `CHECK("takes", 64 >> f, take_count - c0)
            rd(STATUS_ADDR, p0);
            rd(STATUS_ADDR, rv);
            `CHECK("lo step", (f == 3) ? 2'd1 : 2'd2, 2'(rv - p0))
        end
        run_mode(mv(INTERP_8X, 1'b1, LO_OFF, 1'b0, 1'b0), '{'{A, B}, '{NA, NB}, '{A, B}, '{NA, NB}});
        run_mode(mv(INTERP_1X, 1'b0, LO_QUARTER, 1'b1, 1'b0), '{'{A, B}, '{NB, A}, '{NA, NB}, '{B, NA}});
        run_mode(mv(INTERP_1X, 1'b0, LO_QUARTER, 1'b1, 1'b1), '{'{A, B}, '{B, A}, '{NA, NB}, '{NB, NA}});
        run_mode(mv(INTERP_1X, 1'b0, LO_HALF, 1'b0, 1'b0), '{'{NA, NA}, '{A, A}, '{NA, NA}, '{A, A}});
        run_mode(mv(INTERP_1X, 1'b0, LO_HALF, 1'b1, 1'b0), '{'{NA, NA}, '{A, A}, '{NA, NA}, '{A, A}});
        run_mode(mv(INTERP_1X, 1'b0, lo_sel_type'(2'b11), 1'b1, 1'b0), '{'{A, B}, '{A, B}, '{A, B}, '{A, B}});
        run_mode(mv(INTERP_1X, 1'b0, LO_QUARTER, 1'b0, 1'b0), '{'{A, A}, '{Z, Z}, '{NA, NA}, '{Z, Z}});
        for (int k = 0; k < 4; k++) begin
            wr(CTRL0_ADDR, pd_val[k]);
            @(negedge mclk);
            `CHECK("power-down", pd_exp[k], {dac_i_power_down, dac_q_power_down, filters_power_down, full_power_down})
            if (pd_exp[k][1]) begin
                hold = dac_out;
                repeat (4) @(negedge mclk);
                `CHECK("held dac_out", hold, dac_out)
                `CHECK("sample_take frozen", 1'b0, sample_take)
            end
            rd(STATUS_ADDR, rv);
            `CHECK("status full power-down", pd_exp[k][0], rv[STATUS_FULL_PD_BIT])
            wr(CTRL0_ADDR, 8'h00);
        end
        do_reset();
        rd(STATUS_ADDR, rv);
        `CHECK("start phase", ref_status, rv)
        give_verdict();
    end
endmodule
